// *** include/temp_alarm_pkg.sv ***
package temp_alarm_pkg;

    // Channel count and width of one converted reading.
    localparam int CHANNELS = 4;
    localparam int READING_W = 8;

    // Channel codes; the conversion order is set by the sequencer.
    typedef enum logic [1:0] {
        CH_LOCAL = 2'h0,
        CH_REMOTE1 = 2'h1,
        CH_REMOTE2 = 2'h2,
        CH_REMOTE3 = 2'h3
    } chan_t;

    // Register byte offsets; per-channel registers sit one word apart.
    localparam logic [7:0] READING_BASE = 8'h00;
    localparam logic [7:0] HIGH_BASE = 8'h10;
    localparam logic [7:0] CRIT_OFS = 8'h20;
    localparam logic [7:0] STATUS_OFS = 8'h24;
    localparam logic [7:0] CONTROL_OFS = 8'h28;

    // Field positions.
    localparam int STATUS_HIGH_LSB = 0;
    localparam int STATUS_CRIT_LSB = 4;
    localparam int CONTROL_RUN_BIT = 0;
    localparam int CONTROL_CHAN_LSB = 2;

    // Values after reset.
    localparam logic [7:0] SETPOINT_RESET = 8'h7F;
    localparam logic [7:0] READING_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h01;

    // Times as specified, and the clock rate they are converted at.
    localparam longint CLK_HZ = 200000000;
    localparam longint SLOT_MS = 120;
    localparam longint TIMEOUT_MIN_MS = 25;
    localparam longint TIMEOUT_MAX_MS = 40;
    localparam longint STRETCH_MAX_MS = 10;

    // Cycle counts: least times round up, longest times round down.
    localparam int unsigned SLOT_CYCLES =
        32'(SLOT_MS * CLK_HZ / 1000);
    localparam int unsigned TIMEOUT_CYCLES =
        32'((TIMEOUT_MIN_MS * CLK_HZ + 999) / 1000);
    localparam int unsigned TIMEOUT_LIMIT_CYCLES =
        32'(TIMEOUT_MAX_MS * CLK_HZ / 1000);
    localparam int unsigned STRETCH_CYCLES =
        32'(STRETCH_MAX_MS * CLK_HZ / 1000);

endpackage

// *** hw/conv_sequencer.sv ***
`timescale 1ns/1ps
module conv_sequencer #(
    parameter int unsigned SLOT_CYCLES = temp_alarm_pkg::SLOT_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic run_i,
    output temp_alarm_pkg::chan_t channel_o,
    output logic done_o
);

    logic [31:0] slot_cnt_q;
    temp_alarm_pkg::chan_t channel_q;
    logic done_q;

    // Round-robin order: local, remote 2, remote 1, remote 3.
    function automatic temp_alarm_pkg::chan_t next_channel(
        input temp_alarm_pkg::chan_t cur
    );
        unique case (cur)
            temp_alarm_pkg::CH_LOCAL: next_channel = temp_alarm_pkg::CH_REMOTE2;
            temp_alarm_pkg::CH_REMOTE2: next_channel = temp_alarm_pkg::CH_REMOTE1;
            temp_alarm_pkg::CH_REMOTE1: next_channel = temp_alarm_pkg::CH_REMOTE3;
            temp_alarm_pkg::CH_REMOTE3: next_channel = temp_alarm_pkg::CH_LOCAL;
        endcase
    endfunction

    // Each slot lasts SLOT_CYCLES; the last cycle marks the conversion done.
    // Stopping the run holds the slot where it is rather than restarting it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slot_cnt_q <= 32'h0;
            channel_q <= temp_alarm_pkg::CH_LOCAL;
            done_q <= 1'b0;
        end else if (ce_i) begin
            done_q <= 1'b0;
            if (run_i) begin
                if (slot_cnt_q == 32'(SLOT_CYCLES - 1)) begin
                    slot_cnt_q <= 32'h0;
                    done_q <= 1'b1;
                    channel_q <= next_channel(channel_q);
                end else begin
                    slot_cnt_q <= slot_cnt_q + 32'h1;
                end
            end
        end
    end

    // Channel of the pulse: done_o reports the slot that just ended.
    temp_alarm_pkg::chan_t done_chan_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_chan_q <= temp_alarm_pkg::CH_LOCAL;
        end else if (ce_i && run_i && slot_cnt_q == 32'(SLOT_CYCLES - 1)) begin
            done_chan_q <= channel_q;
        end
    end

    assign channel_o = done_o ? done_chan_q : channel_q;
    assign done_o = done_q;

endmodule

// *** hw/temp_limit_alarm_logic.sv ***
// Our own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
module temp_limit_alarm_logic #(
    parameter int unsigned SLOT_CYCLES = temp_alarm_pkg::SLOT_CYCLES,
    parameter int unsigned TIMEOUT_CYCLES = temp_alarm_pkg::TIMEOUT_CYCLES,
    parameter int unsigned STRETCH_CYCLES = temp_alarm_pkg::STRETCH_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [7:0] adc_result_i,
    output logic [1:0] adc_channel_o,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    input wire logic stretch_req_i,
    input wire logic sda_pull_i,
    output logic serial_reset_o,
    output logic high_alarm_n_o,
    output logic critical_alarm_n_o
);

    localparam int N = temp_alarm_pkg::CHANNELS;
    localparam int W = temp_alarm_pkg::READING_W;

    ////////////////////////////////////////////////////////////////////////
    // Conversion timebase.

    temp_alarm_pkg::chan_t conv_chan;
    logic conv_done;
    logic run_q;

    conv_sequencer #(
        .SLOT_CYCLES(SLOT_CYCLES)
    ) u_seq (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .run_i(run_q),
        .channel_o(conv_chan),
        .done_o(conv_done)
    );

    // The converter is told which input is being digitised.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            adc_channel_o <= 2'h0;
        end else if (ce_i) begin
            adc_channel_o <= conv_chan;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register bus decode.

    // Word-aligned match of the bus address against a register offset.
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
        hit = (adr[7:2] == ofs[7:2]);
    endfunction

    logic bus_req;
    logic wr_en;
    logic rd_status;
    logic ack_q;

    // A request is taken once; the ack lasts one cycle.
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr_en = bus_req && wb_we_i && wb_sel_i[0];
    assign rd_status = bus_req && !wb_we_i
        && hit(wb_adr_i, temp_alarm_pkg::STATUS_OFS);

    logic [W-1:0] reading_q [N];
    logic [W-1:0] high_sp_q [N];
    logic [W-1:0] crit_sp_q;
    logic [N-1:0] high_flag_q;
    logic [N-1:0] crit_flag_q;
    logic [N-1:0] high_latch_q;
    logic [N-1:0] read_seen_q;
    logic [N-1:0] crit_over_q;

    ////////////////////////////////////////////////////////////////////////
    // Per-channel readings, setpoints, flags and alarm latches.

    genvar c;
    generate
        for (c = 0; c < N; c++) begin : g_chan
            logic done_here;
            logic over_high;
            logic over_crit;
            assign done_here = conv_done && (conv_chan == c);
            // Signed strict compare of the fresh result, not the stored one.
            assign over_high =
                $signed(adc_result_i) > $signed(high_sp_q[c]);
            assign over_crit =
                $signed(adc_result_i) > $signed(crit_sp_q);

            // The word changes in one edge, so no read sees half of it.
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    reading_q[c] <= temp_alarm_pkg::READING_RESET;
                end else if (ce_i && done_here) begin
                    reading_q[c] <= adc_result_i;
                end
            end

            // Setpoint written through byte lane 0.
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    high_sp_q[c] <= temp_alarm_pkg::SETPOINT_RESET;
                end else if (ce_i && wr_en && hit(wb_adr_i,
                        8'(temp_alarm_pkg::HIGH_BASE + 8'(4 * c)))) begin
                    high_sp_q[c] <= wb_dat_i[W-1:0];
                end
            end

            // Sticky status flags: a set in the reading cycle wins.
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    high_flag_q[c] <= 1'b0;
                    crit_flag_q[c] <= 1'b0;
                end else if (ce_i) begin
                    high_flag_q[c] <= (high_flag_q[c] && !rd_status)
                        || (done_here && over_high);
                    crit_flag_q[c] <= (crit_flag_q[c] && !rd_status)
                        || (done_here && over_crit);
                end
            end

            // The high alarm latch drops only after the host saw the flag
            // and a later conversion of this channel is at or below limit.
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    high_latch_q[c] <= 1'b0;
                    read_seen_q[c] <= 1'b0;
                end else if (ce_i) begin
                    if (done_here && over_high) begin
                        high_latch_q[c] <= 1'b1;
                        read_seen_q[c] <= 1'b0;
                    end else if (done_here && read_seen_q[c]) begin
                        high_latch_q[c] <= 1'b0;
                        read_seen_q[c] <= 1'b0;
                    end else if (rd_status && high_flag_q[c]) begin
                        read_seen_q[c] <= 1'b1;
                    end
                end
            end

            // Critical state follows the latest result of this channel.
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    crit_over_q[c] <= 1'b0;
                end else if (ce_i && done_here) begin
                    crit_over_q[c] <= over_crit;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Shared critical setpoint and control.

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            crit_sp_q <= temp_alarm_pkg::SETPOINT_RESET;
        end else if (ce_i && wr_en && hit(wb_adr_i, temp_alarm_pkg::CRIT_OFS)) begin
            crit_sp_q <= wb_dat_i[W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_q <= temp_alarm_pkg::CONTROL_RESET[temp_alarm_pkg::CONTROL_RUN_BIT];
        end else if (ce_i && wr_en
                && hit(wb_adr_i, temp_alarm_pkg::CONTROL_OFS)) begin
            run_q <= wb_dat_i[temp_alarm_pkg::CONTROL_RUN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data and acknowledge.

    // Unmapped addresses still acknowledge and read as zero, so a stray
    // access cannot hang the master.
    logic [31:0] rd_d;
    always_comb begin
        rd_d = 32'h0;
        for (int i = 0; i < N; i++) begin
            if (hit(wb_adr_i, 8'(temp_alarm_pkg::READING_BASE + 8'(4 * i)))) begin
                rd_d[W-1:0] = reading_q[i];
            end
            if (hit(wb_adr_i, 8'(temp_alarm_pkg::HIGH_BASE + 8'(4 * i)))) begin
                rd_d[W-1:0] = high_sp_q[i];
            end
        end
        if (hit(wb_adr_i, temp_alarm_pkg::CRIT_OFS)) begin
            rd_d[W-1:0] = crit_sp_q;
        end
        if (hit(wb_adr_i, temp_alarm_pkg::STATUS_OFS)) begin
            rd_d[temp_alarm_pkg::STATUS_HIGH_LSB +: N] = high_flag_q;
            rd_d[temp_alarm_pkg::STATUS_CRIT_LSB +: N] = crit_flag_q;
        end
        if (hit(wb_adr_i, temp_alarm_pkg::CONTROL_OFS)) begin
            rd_d[temp_alarm_pkg::CONTROL_RUN_BIT] = run_q;
            rd_d[temp_alarm_pkg::CONTROL_CHAN_LSB +: 2] = conv_chan;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            wb_dat_o <= 32'h0;
        end else if (ce_i) begin
            ack_q <= bus_req;
            if (bus_req && !wb_we_i) begin
                wb_dat_o <= rd_d;
            end
        end
    end
    assign wb_ack_o = ack_q;

    ////////////////////////////////////////////////////////////////////////
    // Alarm outputs, active low.

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            high_alarm_n_o <= 1'b1;
            critical_alarm_n_o <= 1'b1;
        end else if (ce_i) begin
            high_alarm_n_o <= !(|high_latch_q);
            critical_alarm_n_o <= !(|crit_over_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial line watch: synchronisers, timeout and clock stretch.

    logic scl_meta_q;
    logic scl_s_q;
    logic scl_h_q;
    logic sda_meta_q;
    logic sda_s_q;
    logic sda_h_q;

    // Two flops per pin, then a history flop for edge finding.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scl_meta_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_h_q <= 1'b1;
            sda_meta_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_h_q <= 1'b1;
        end else if (ce_i) begin
            scl_meta_q <= scl_i;
            scl_s_q <= scl_meta_q;
            scl_h_q <= scl_s_q;
            sda_meta_q <= sda_i;
            sda_s_q <= sda_meta_q;
            sda_h_q <= sda_s_q;
        end
    end

    logic stop_seen;
    logic line_low;
    assign stop_seen = scl_s_q && sda_s_q && !sda_h_q;
    assign line_low = !scl_s_q || !sda_s_q;

    logic [31:0] low_cnt_q;
    logic timed_out_q;
    logic serial_reset_q;

    // Timeout: either line low for TIMEOUT_CYCLES forces the interface
    // idle; our drivers stay released until both lines read high again.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_cnt_q <= 32'h0;
            timed_out_q <= 1'b0;
            serial_reset_q <= 1'b0;
        end else if (ce_i) begin
            serial_reset_q <= 1'b0;
            if (!line_low) begin
                low_cnt_q <= 32'h0;
                timed_out_q <= 1'b0;
            end else if (!timed_out_q) begin
                if (low_cnt_q == 32'(TIMEOUT_CYCLES - 1)) begin
                    timed_out_q <= 1'b1;
                    serial_reset_q <= 1'b1;
                end else begin
                    low_cnt_q <= low_cnt_q + 32'h1;
                end
            end
        end
    end
    assign serial_reset_o = serial_reset_q;

    logic [31:0] stretch_cnt_q;
    logic stretch_q;
    logic budget_left;
    // The cycle about to be held counts as well, so the total never passes
    // the budget by one.
    assign budget_left = (stretch_cnt_q + 32'h1) < 32'(STRETCH_CYCLES);

    // Stretch only once the master has pulled the clock low; the budget is
    // cumulative per transfer and refills at a stop or an idle reset.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stretch_cnt_q <= 32'h0;
            stretch_q <= 1'b0;
        end else if (ce_i) begin
            if (stop_seen || timed_out_q) begin
                stretch_cnt_q <= 32'h0;
                stretch_q <= 1'b0;
            end else begin
                stretch_q <= stretch_req_i && budget_left
                    && (stretch_q || !scl_s_q);
                if (stretch_q) begin
                    stretch_cnt_q <= stretch_cnt_q + 32'h1;
                end
            end
        end
    end

    // Open-drain drive: the enable is low while the pin is pulled low.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
            scl_oe_n_o <= 1'b1;
            sda_oe_n_o <= 1'b1;
        end else if (ce_i) begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
            scl_oe_n_o <= !(stretch_req_i && budget_left && !timed_out_q
                && !stop_seen && (stretch_q || !scl_s_q));
            sda_oe_n_o <= !(sda_pull_i && !timed_out_q);
        end
    end

endmodule

// *** bench/temp_limit_alarm_asserts.sv ***
`timescale 1ns/1ps
module temp_limit_alarm_asserts #(
    parameter int unsigned SLOT_CYCLES = 50,
    parameter int unsigned TIMEOUT_CYCLES = 40,
    parameter int unsigned STRETCH_CYCLES = 10
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [1:0] adc_channel_o,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic scl_oe_n_o,
    input wire logic sda_oe_n_o,
    input wire logic serial_reset_o,
    input wire logic high_alarm_n_o,
    input wire logic critical_alarm_n_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic [31:0] low_cnt_q;
    logic [31:0] slot_cnt_q;
    logic [31:0] str_cnt_q;
    logic [1:0] ch_prev_q;
    logic sda_prev_q;

    // How long either line has been low; cleared once both read high.
    always_ff @(posedge clk_i) begin
        if (rst_i || (scl_i && sda_i)) begin
            low_cnt_q <= 32'h0;
        end else begin
            low_cnt_q <= low_cnt_q + 32'h1;
        end
    end

    // Cycles since the converter last moved to another channel.
    always_ff @(posedge clk_i) begin
        ch_prev_q <= adc_channel_o;
        if (rst_i || adc_channel_o != ch_prev_q) begin
            slot_cnt_q <= 32'h0;
        end else begin
            slot_cnt_q <= slot_cnt_q + 32'h1;
        end
    end

    // Clock extension used since the last stop or timeout. Clearing on the
    // raw stop is earlier than the design can see it, so this errs lenient.
    always_ff @(posedge clk_i) begin
        sda_prev_q <= sda_i;
        if (rst_i || serial_reset_o || (scl_i && sda_i && !sda_prev_q)) begin
            str_cnt_q <= 32'h0;
        end else if (!scl_oe_n_o) begin
            str_cnt_q <= str_cnt_q + 32'h1;
        end
    end

    ////////////////////////////////////////
    AST_ACK_NEXT:
        assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
        else $error("request not answered in the next cycle");
    AST_ACK_PULSE:
        assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
    AST_READ_UPPER:
        assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data wider than a byte");
    AST_ORDER:
        assert property (adc_channel_o != ch_prev_q |->
            adc_channel_o == {~ch_prev_q[1], ch_prev_q[1] ^ ch_prev_q[0]})
        else $error("conversion order broken");
    AST_SLOT_LEN:
        assert property (adc_channel_o != ch_prev_q |->
            slot_cnt_q >= SLOT_CYCLES - 2)
        else $error("conversion slot too short");
    // The alarm pins and the channel output both move two cycles after the
    // done pulse, so they change on the same edge.
    AST_ALARM_AT_CONV:
        assert property ($changed(high_alarm_n_o) ||
            $changed(critical_alarm_n_o) |->
            adc_channel_o != $past(adc_channel_o))
        else $error("alarm moved away from a conversion end");
    AST_TIMEOUT_RELEASE:
        assert property (low_cnt_q == TIMEOUT_CYCLES + 8 |->
            scl_oe_n_o && sda_oe_n_o)
        else $error("lines not released after timeout");
    AST_NOT_EARLY:
        assert property (serial_reset_o |-> low_cnt_q >= TIMEOUT_CYCLES)
        else $error("serial reset before the timeout");
    AST_STRETCH_BUDGET:
        assert property (str_cnt_q <= STRETCH_CYCLES)
        else $error("clock extension over budget");

    COV_TIMEOUT: cover property (serial_reset_o);
    COV_CRIT: cover property ($fell(critical_alarm_n_o));
    COV_HIGH_CLEAR: cover property ($rose(high_alarm_n_o));
    COV_STRETCH: cover property ($fell(scl_oe_n_o));
endmodule

bind temp_limit_alarm_logic temp_limit_alarm_asserts #(
    .SLOT_CYCLES(SLOT_CYCLES), .TIMEOUT_CYCLES(TIMEOUT_CYCLES),
    .STRETCH_CYCLES(STRETCH_CYCLES)) u_temp_limit_alarm_asserts (
    .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
    .adc_channel_o, .scl_i, .sda_i, .scl_oe_n_o, .sda_oe_n_o,
    .serial_reset_o, .high_alarm_n_o, .critical_alarm_n_o);

// *** bench/smbus_host_model.sv ***
`timescale 1ns/1ps
module smbus_host_model (
    input wire logic frame_i,
    input wire logic stuck_i,
    input wire logic scl_oe_n_i,
    input wire logic sda_oe_n_i,
    output logic scl_line_o,
    output logic sda_line_o
);
    logic scl_q = 1'b1;
    logic sda_q = 1'b1;

    // Open-drain lines with pull-ups: low if any party pulls.
    assign scl_line_o = scl_q & scl_oe_n_i;
    assign sda_line_o = sda_q & sda_oe_n_i & !stuck_i;

    // One frame per request: start, four clocks, stop. The clock stands
    // high between frames, and each high phase waits for a stretch to end.
    always begin
        wait (frame_i);
        #7 sda_q = 1'b0;
        repeat (4) begin
            #24 scl_q = 1'b0;
            #24 scl_q = 1'b1;
            wait (scl_line_o);
        end
        #12 sda_q = 1'b1;
        #24;
    end
endmodule

// *** bench/temp_limit_alarm_logic_tb.sv ***
`timescale 1ns/1ps
module temp_limit_alarm_logic_tb;
    localparam int SLOT = 50;
    localparam int ROUND = 4 * SLOT + 8;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [1:0] adc_channel_o;
    logic [7:0] adc_result_i;
    logic scl_i, sda_i, scl_o, sda_o, scl_oe_n_o, sda_oe_n_o, serial_reset_o;
    logic high_alarm_n_o, critical_alarm_n_o;
    logic stretch_req_i = 1'b0;
    logic sda_pull_i = 1'b0;
    logic frame = 1'b0;
    logic stuck = 1'b0;
    logic [7:0] temps [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] hs [4] = '{8'h18, 8'hFF, 8'h20, 8'h05};
    logic [1:0] ord [5] = '{2'h0, 2'h2, 2'h1, 2'h3, 2'h0};
    logic [31:0] seen;
    int errors = 0;
    int tests_run = 0;
    int cycles = 0;
    int n;

    // The converter answers with whatever the current channel reads.
    assign adc_result_i = temps[adc_channel_o];
    always #2.5 clk_i = ~clk_i;

    temp_limit_alarm_logic #(.SLOT_CYCLES(SLOT), .TIMEOUT_CYCLES(40),
        .STRETCH_CYCLES(10)) u_temp_limit_alarm_logic (
        .clk_i, .rst_i, .ce_i(1'b1), .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .adc_result_i, .adc_channel_o, .scl_i, .scl_o, .scl_oe_n_o,
        .sda_i, .sda_o, .sda_oe_n_o, .stretch_req_i, .sda_pull_i,
        .serial_reset_o, .high_alarm_n_o, .critical_alarm_n_o);
    smbus_host_model u_smbus_host_model (.frame_i(frame), .stuck_i(stuck),
        .scl_oe_n_i(scl_oe_n_o), .sda_oe_n_i(sda_oe_n_o),
        .scl_line_o(scl_i), .sda_line_o(sda_i));

    ////////////////////////////////////////
    task automatic summarize;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    // One classic cycle; held until ack is sampled, then released.
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [7:0] d, input logic [3:0] s);
        int k;
        k = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        if (k >= 20) errors++;
        seen = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'h1);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 8'h00, 4'h1);
        chk(seen, e);
    endtask

    // Waits for the timeout pulse, counting the cycles it took.
    task automatic wait_reset;
        n = 0;
        while (serial_reset_o !== 1'b1 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
    endtask

    // A hang counts as a mismatch and still ends in the report.
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            summarize();
        end
    end

    ////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            rdchk(temp_alarm_pkg::HIGH_BASE + 8'(4 * i), 32'h7F);
            rdchk(temp_alarm_pkg::READING_BASE + 8'(4 * i), 32'h0);
        end
        rdchk(temp_alarm_pkg::CRIT_OFS, 32'h7F);
        rdchk(temp_alarm_pkg::STATUS_OFS, 32'h0);
        rdchk(8'h30, 32'h0);
        for (int i = 0; i < 5; i++) begin
            chk(32'(adc_channel_o), 32'(ord[i]));
            n = 0;
            while (adc_channel_o === ord[i] && n < 2 * SLOT) begin
                @(posedge clk_i);
                n++;
            end
            if (i > 0 && i < 4) chk(32'(n), 32'(SLOT));
        end
        // Signed, strict compares: equal, negative and above-unsigned cases.
        temps <= '{8'h19, 8'h80, 8'h20, 8'hE7};
        for (int i = 0; i < 4; i++) begin
            wr(temp_alarm_pkg::HIGH_BASE + 8'(4 * i), hs[i]);
        end
        bus(1'b1, temp_alarm_pkg::HIGH_BASE, 8'h00, 4'h0);
        wr(temp_alarm_pkg::READING_BASE, 8'h55);
        repeat (ROUND) @(posedge clk_i);
        rdchk(temp_alarm_pkg::HIGH_BASE, 32'h18);
        for (int i = 0; i < 4; i++) begin
            rdchk(temp_alarm_pkg::READING_BASE + 8'(4 * i),
                32'(temps[i]));
        end
        chk(32'(high_alarm_n_o), 32'h0);
        chk(32'(critical_alarm_n_o), 32'h1);
        rdchk(temp_alarm_pkg::STATUS_OFS, 32'h01);
        // Read while set, then cool: the high alarm may drop.
        temps[0] <= 8'h10;
        wr(temp_alarm_pkg::CRIT_OFS, 8'h1F);
        repeat (ROUND) @(posedge clk_i);
        chk(32'(high_alarm_n_o), 32'h1);
        chk(32'(critical_alarm_n_o), 32'h0);
        rdchk(temp_alarm_pkg::STATUS_OFS, 32'h40);
        // Hot again, then cool with no read: the alarm must hold.
        temps[0] <= 8'h19;
        repeat (ROUND) @(posedge clk_i);
        chk(32'(high_alarm_n_o), 32'h0);
        temps[0] <= 8'h10;
        repeat (ROUND) @(posedge clk_i);
        chk(32'(high_alarm_n_o), 32'h0);
        rdchk(temp_alarm_pkg::STATUS_OFS, 32'h41);
        repeat (ROUND) @(posedge clk_i);
        chk(32'(high_alarm_n_o), 32'h1);
        // A frame with the clock held as long as the budget allows.
        stretch_req_i <= 1'b1;
        frame <= 1'b1;
        @(posedge clk_i);
        frame <= 1'b0;
        n = 0;
        repeat (120) begin
            @(posedge clk_i);
            if (scl_oe_n_o === 1'b0) n++;
        end
        stretch_req_i <= 1'b0;
        chk(32'(n > 0 && n <= 10), 32'h1);
        // The host sticks data low past the timeout; keep it stuck long
        // enough that the checker sees the released lines as well.
        stuck <= 1'b1;
        wait_reset();
        chk(32'(n >= 40 && n <= 67), 32'h1);
        repeat (8) @(posedge clk_i);
        chk({30'h0, scl_oe_n_o, sda_oe_n_o}, 32'h3);
        chk({30'h0, scl_o, sda_o}, 32'h0);
        stuck <= 1'b0;
        // The device itself holds data low too long and must let go.
        sda_pull_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk(32'(sda_oe_n_o), 32'h0);
        wait_reset();
        @(posedge clk_i);
        chk(32'(sda_oe_n_o), 32'h1);
        sda_pull_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        summarize();
    end
endmodule
